// [logic/eac_cfg.svh]
// Constants for the data NVM access controller
//
// Notes on behaviour
// - Programming in progress survives a reset
// - Nine-bit linear address, upper bits ignored
// - High address bits 7:1 read zero
// - Address undefined at reset; software sets it (reset here loads zero)
// - Data register feeds writes, captures reads
// - Mode field picks atomic, erase, write
// - Mode writes ignored while busy
// - Mode resets to atomic unless busy
// - Ready interrupt held while not busy
// - Master enable self-clears after four cycles
// - Program enable needs live master enable
// - Busy flag clears when time elapses
// - Program start stalls core two cycles
// - Read is immediate, stalls four cycles
// - Busy blocks reads and address changes
// - Port space 0x00-0x3F, data space plus 0x20
// - Low registers allow single-bit set/clear/test
// - Bit operations touch only their bit
// - General store register, plain storage
// - No other operation accepted while busy
// - Write-only on unerased byte is undefined
// - Programming timed from calibrated oscillator
`ifndef EAC_CFG_SVH
`define EAC_CFG_SVH

// ==========================================
// Register map, port space
`define EAC_IO_GP2      6'h0C
`define EAC_IO_CTRL     6'h1C
`define EAC_IO_DATA     6'h1D
`define EAC_IO_ADRL     6'h1E
`define EAC_IO_ADRH     6'h1F
`define EAC_IO_BIT_TOP  6'h1F
`define EAC_DS_OFS      7'h20
`define EAC_DS_TOP      7'h60

// ==========================================
// Control register fields
`define EAC_B_RE        0
`define EAC_B_PE        1
`define EAC_B_MPE       2
`define EAC_B_RIE       3
`define EAC_B_PM_LO     4
`define EAC_B_PM_HI     5

// ==========================================
// Reset values and cycle counts
`define EAC_RST_BYTE    8'h00
`define EAC_ERASED      8'hFF
`define EAC_MPE_CYC     3'h4
`define EAC_STALL_RD    3'h4
`define EAC_STALL_PE    3'h2

// ==========================================
// Programming times in microseconds
`define EAC_T_ATOMIC_US 3400
`define EAC_T_SPLIT_US  1800

`endif

// [logic/eac_pkg.sv]
// Types shared by the data NVM access controller
package eac_pkg;
   typedef enum logic [1:0] {
      EAC_MODE_ATOMIC = 2'b00,
      EAC_MODE_ERASE  = 2'b01,
      EAC_MODE_WRITE  = 2'b10,
      EAC_MODE_RSVD   = 2'b11
   } eac_mode_e;

   typedef enum logic {
      EAC_ENG_IDLE = 1'b0,
      EAC_ENG_BUSY = 1'b1
   } eac_eng_e;
endpackage

// [logic/eac_prog_timer.sv]
// Programming duration timer on the core clock, counting oscillator edges
`timescale 1ns/1ps
module eac_prog_timer #(
   parameter int unsigned CNT_W       = 16,
   parameter int unsigned LONG_TICKS  = 27200,
   parameter int unsigned SHORT_TICKS = 14400
)(
   input  wire logic mclk_i,
   input  wire logic rstn_i,
   input  wire logic osc_i,
   input  wire logic start_i,
   input  wire logic long_i,
   output logic      done_o
);
   logic             osc_s1_ff, osc_s2_ff, osc_s3_ff;
   logic             run_ff, nxt_run;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic             done_ff, nxt_done;
   logic             tick;

   // ==========================================
   // Oscillator sync; edge found from the second and third stages
   assign tick = osc_s2_ff & ~osc_s3_ff;

   always_comb begin
      nxt_run  = run_ff;
      nxt_cnt  = cnt_ff;
      nxt_done = 1'b0;
      if (start_i) begin
         nxt_run = 1'b1;
         nxt_cnt = long_i ? CNT_W'(LONG_TICKS) : CNT_W'(SHORT_TICKS);
      end else if (run_ff && tick) begin
         // Count oscillator edges, not core cycles
         nxt_cnt = cnt_ff - 1'b1;
         if (cnt_ff <= CNT_W'(1)) begin
            nxt_run  = 1'b0;
            nxt_done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
         osc_s3_ff <= 1'b0;
         run_ff    <= 1'b0;
         cnt_ff    <= '0;
         done_ff   <= 1'b0;
      end else begin
         osc_s1_ff <= osc_i;
         osc_s2_ff <= osc_s1_ff;
         osc_s3_ff <= osc_s2_ff;
         run_ff    <= nxt_run;
         cnt_ff    <= nxt_cnt;
         done_ff   <= nxt_done;
      end
   end

   assign done_o = done_ff;
endmodule

// [logic/eac_nvm_array.sv]
// Byte array standing in for the data NVM cells
`timescale 1ns/1ps
`include "eac_cfg.svh"
module eac_nvm_array #(
   parameter int unsigned AW = 9
)(
   input  wire logic          mclk_i,
   input  wire logic [AW-1:0] rd_addr_i,
   output logic [7:0]         rd_data_o,
   input  wire logic          we_i,
   input  wire logic [1:0]    mode_i,
   input  wire logic [AW-1:0] wr_addr_i,
   input  wire logic [7:0]    wr_data_i
);
   logic [7:0] mem_q [0:(1<<AW)-1];

   assign rd_data_o = mem_q[rd_addr_i];

   // Write-only keeps old cleared bits, so an unerased byte turns to garbage
   always_ff @(posedge mclk_i) begin
      if (we_i) begin
         case (eac_pkg::eac_mode_e'(mode_i))
            eac_pkg::EAC_MODE_ATOMIC: mem_q[wr_addr_i] <= wr_data_i;
            eac_pkg::EAC_MODE_ERASE:  mem_q[wr_addr_i] <= `EAC_ERASED;
            eac_pkg::EAC_MODE_WRITE:  mem_q[wr_addr_i] <= mem_q[wr_addr_i] & wr_data_i;
            default:                  mem_q[wr_addr_i] <= mem_q[wr_addr_i];
         endcase
      end
   end
endmodule

// [logic/eac_ctrl.sv]
// Data NVM access controller with general store register, top level
`timescale 1ns/1ps
`include "eac_cfg.svh"
module eac_ctrl #(
   parameter int unsigned OSC_KHZ     = 8000,
   parameter int unsigned MEM_AW      = 9,
   parameter int unsigned LONG_TICKS  = `EAC_T_ATOMIC_US * OSC_KHZ / 1000,
   parameter int unsigned SHORT_TICKS = `EAC_T_SPLIT_US * OSC_KHZ / 1000
)(
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   input  wire logic       por_resetn_i,
   input  wire logic       calib_osc_i,
   input  wire logic [6:0] io_addr_i,
   input  wire logic       io_dspace_i,
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   input  wire logic [7:0] io_wdata_i,
   input  wire logic       io_bit_op_i,
   input  wire logic       io_bit_val_i,
   input  wire logic [2:0] io_bit_sel_i,
   input  wire logic       global_irq_en_i,
   output logic [7:0]      io_rdata_o,
   output logic            ready_irq_o,
   output logic            stall_o
);
   // ==========================================
   // Helpers
   function automatic logic [6:0] dec_f(input logic [6:0] a, input logic ds);
      logic [6:0] r;
      r = 7'h00;
      if (!ds) begin
         r = {~a[6], a[5:0]};
      end else if (a >= `EAC_DS_OFS && a < `EAC_DS_TOP) begin
         r = {1'b1, 6'(a - `EAC_DS_OFS)};
      end
      return r;
   endfunction

   function automatic logic [7:0] merge_f(input logic [7:0] o, input logic [7:0] v,
                                          input logic [7:0] m);
      return (o & ~m) | (v & m);
   endfunction

   // ==========================================
   // Access decode
   logic [6:0] dec;
   logic       hit;
   logic [5:0] idx;
   logic       bit_ok;
   logic       wr_go;
   logic [7:0] wmask;
   logic [7:0] wval;
   logic       wr_ctrl, wr_data, wr_adrl, wr_adrh, wr_gp2;

   assign dec    = dec_f(io_addr_i, io_dspace_i);
   assign hit    = dec[6];
   assign idx    = dec[5:0];
   // Bit access only reaches the low half of port space
   assign bit_ok = !io_dspace_i && (idx <= `EAC_IO_BIT_TOP);
   assign wr_go  = io_wr_i && hit && (!io_bit_op_i || bit_ok);
   // A bit access writes through a one-hot mask, so neighbours keep state
   assign wmask  = io_bit_op_i ? 8'(8'h01 << io_bit_sel_i) : 8'hFF;
   assign wval   = io_bit_op_i ? (io_bit_val_i ? wmask : 8'h00) : io_wdata_i;
   assign wr_ctrl = wr_go && (idx == `EAC_IO_CTRL);
   assign wr_data = wr_go && (idx == `EAC_IO_DATA);
   assign wr_adrl = wr_go && (idx == `EAC_IO_ADRL);
   assign wr_adrh = wr_go && (idx == `EAC_IO_ADRH);
   assign wr_gp2  = wr_go && (idx == `EAC_IO_GP2);

   // ==========================================
   // Core-reset registers
   logic [7:0] gp2_ff, nxt_gp2;
   logic [7:0] data_ff, nxt_data;
   logic [8:0] addr_ff, nxt_addr;
   logic       rie_ff, nxt_rie;
   logic [2:0] mpe_cnt_ff, nxt_mpe_cnt;
   logic [2:0] stall_ff, nxt_stall;
   logic [7:0] rdata_ff, nxt_rdata;

   // Engine state, held across a core reset except an idle mode, which returns to atomic
   eac_pkg::eac_eng_e  eng_ff, nxt_eng;
   eac_pkg::eac_mode_e mode_ff, nxt_mode;
   logic [8:0]         op_addr_ff, nxt_op_addr;
   logic [7:0]         op_data_ff, nxt_op_data;
   logic               rsn_s1_ff, rsn_s2_ff;

   logic       busy;
   logic       mpe_on;
   logic       pe_wr;
   logic       start;
   logic       rd_go;
   logic       done;
   logic [7:0] mem_rd;
   logic [7:0] ctrl_val;

   assign busy   = (eng_ff == eac_pkg::EAC_ENG_BUSY);
   assign mpe_on = (mpe_cnt_ff != 3'h0);
   assign pe_wr  = wr_ctrl && wmask[`EAC_B_PE] && wval[`EAC_B_PE];
   // No start without a live master enable, nor while busy or reserved
   assign start  = pe_wr && mpe_on && !busy && rsn_s2_ff &&
                   (mode_ff != eac_pkg::EAC_MODE_RSVD);
   // Busy refuses reads
   assign rd_go  = wr_ctrl && wmask[`EAC_B_RE] && wval[`EAC_B_RE] && !busy;
   assign ctrl_val = {2'b00, mode_ff, rie_ff, mpe_on, busy, 1'b0};

   always_comb begin
      nxt_gp2     = gp2_ff;
      nxt_data    = data_ff;
      nxt_addr    = addr_ff;
      nxt_rie     = rie_ff;
      nxt_mpe_cnt = mpe_on ? mpe_cnt_ff - 3'h1 : 3'h0;
      nxt_stall   = (stall_ff != 3'h0) ? stall_ff - 3'h1 : 3'h0;
      nxt_rdata   = rdata_ff;
      if (wr_gp2) begin
         nxt_gp2 = merge_f(gp2_ff, wval, wmask);
      end
      if (rd_go) begin
         nxt_data  = mem_rd;
         nxt_stall = `EAC_STALL_RD;
      end else if (wr_data) begin
         nxt_data = merge_f(data_ff, wval, wmask);
      end
      if (start) begin
         nxt_stall = `EAC_STALL_PE;
      end
      // Address is frozen against writes for the whole programming time
      if (wr_adrl && !busy) begin
         nxt_addr[7:0] = merge_f(addr_ff[7:0], wval, wmask);
      end
      if (wr_adrh && !busy) begin
         nxt_addr[8] = (wval[0] & wmask[0]) | (addr_ff[8] & ~wmask[0]);
      end
      if (wr_ctrl) begin
         nxt_rie = (wval[`EAC_B_RIE] & wmask[`EAC_B_RIE]) |
                   (rie_ff & ~wmask[`EAC_B_RIE]);
         if (wmask[`EAC_B_MPE] && wval[`EAC_B_MPE]) begin
            nxt_mpe_cnt = `EAC_MPE_CYC;
         end
      end
      if (io_rd_i) begin
         nxt_rdata = 8'h00;
         if (hit) begin
            case (idx)
               `EAC_IO_GP2:  nxt_rdata = gp2_ff;
               `EAC_IO_CTRL: nxt_rdata = ctrl_val;
               `EAC_IO_DATA: nxt_rdata = data_ff;
               `EAC_IO_ADRL: nxt_rdata = addr_ff[7:0];
               `EAC_IO_ADRH: nxt_rdata = {7'h00, addr_ff[8]};
               default:      nxt_rdata = 8'h00;
            endcase
         end
      end
   end

   // Address is left at zero here; software still must load it first
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gp2_ff     <= `EAC_RST_BYTE;
         data_ff    <= `EAC_RST_BYTE;
         addr_ff    <= 9'h000;
         rie_ff     <= 1'b0;
         mpe_cnt_ff <= 3'h0;
         stall_ff   <= 3'h0;
         rdata_ff   <= `EAC_RST_BYTE;
      end else begin
         gp2_ff     <= nxt_gp2;
         data_ff    <= nxt_data;
         addr_ff    <= nxt_addr;
         rie_ff     <= nxt_rie;
         mpe_cnt_ff <= nxt_mpe_cnt;
         stall_ff   <= nxt_stall;
         rdata_ff   <= nxt_rdata;
      end
   end

   // ==========================================
   // Programming engine on the power-on reset
   always_comb begin
      nxt_eng     = eng_ff;
      nxt_mode    = mode_ff;
      nxt_op_addr = op_addr_ff;
      nxt_op_data = op_data_ff;
      case (eng_ff)
         eac_pkg::EAC_ENG_IDLE: begin
            if (!rsn_s2_ff) begin
               nxt_mode = eac_pkg::EAC_MODE_ATOMIC;
            end else if (wr_ctrl && !start) begin
               // A start runs on the mode already held, so timer and array agree
               nxt_mode = eac_pkg::eac_mode_e'(2'(merge_f({2'b00, mode_ff, 4'h0}, wval,
                                                          wmask) >> `EAC_B_PM_LO));
            end
            if (start) begin
               nxt_eng     = eac_pkg::EAC_ENG_BUSY;
               nxt_op_addr = addr_ff;
               nxt_op_data = data_ff;
            end
         end
         eac_pkg::EAC_ENG_BUSY: begin
            // Mode held against both writes and core reset
            if (done) begin
               nxt_eng = eac_pkg::EAC_ENG_IDLE;
            end
         end
         default: nxt_eng = eac_pkg::EAC_ENG_IDLE;
      endcase
   end

   // Core reset reaches this group only through a synchroniser
   always_ff @(posedge mclk_i or negedge por_resetn_i) begin
      if (!por_resetn_i) begin
         eng_ff     <= eac_pkg::EAC_ENG_IDLE;
         mode_ff    <= eac_pkg::EAC_MODE_ATOMIC;
         op_addr_ff <= 9'h000;
         op_data_ff <= `EAC_RST_BYTE;
         rsn_s1_ff  <= 1'b0;
         rsn_s2_ff  <= 1'b0;
      end else begin
         eng_ff     <= nxt_eng;
         mode_ff    <= nxt_mode;
         op_addr_ff <= nxt_op_addr;
         op_data_ff <= nxt_op_data;
         rsn_s1_ff  <= resetn_i;
         rsn_s2_ff  <= rsn_s1_ff;
      end
   end

   eac_prog_timer #(
      .CNT_W       (16),
      .LONG_TICKS  (LONG_TICKS),
      .SHORT_TICKS (SHORT_TICKS)
   ) u_timer (
      .mclk_i  (mclk_i),
      .rstn_i  (por_resetn_i),
      .osc_i   (calib_osc_i),
      .start_i (start),
      .long_i  (mode_ff == eac_pkg::EAC_MODE_ATOMIC),
      .done_o  (done)
   );

   eac_nvm_array #(
      .AW (MEM_AW)
   ) u_array (
      .mclk_i    (mclk_i),
      .rd_addr_i (addr_ff[MEM_AW-1:0]),
      .rd_data_o (mem_rd),
      .we_i      (done),
      .mode_i    (mode_ff),
      .wr_addr_i (op_addr_ff[MEM_AW-1:0]),
      .wr_data_i (op_data_ff)
   );

   // ==========================================
   // Outputs
   assign io_rdata_o  = rdata_ff;
   assign ready_irq_o = rie_ff & global_irq_en_i & ~busy;
   assign stall_o     = (stall_ff != 3'h0);

   // ==========================================
   // Checks
   logic mpe_set;
   assign mpe_set = wr_ctrl && wmask[`EAC_B_MPE] && wval[`EAC_B_MPE];

   property p_hi_reserved;
      @(posedge mclk_i) disable iff (!resetn_i)
      io_rd_i && hit && idx == `EAC_IO_ADRH |=> io_rdata_o[7:1] == 7'h00;
   endproperty
   a_hi_reserved: assert property (p_hi_reserved) else $error("high addr reserved bits set");

   property p_mpe_clear;
      @(posedge mclk_i) disable iff (!resetn_i)
      mpe_set ##1 !mpe_set [*4] |=> !mpe_on;
   endproperty
   a_mpe_clear: assert property (p_mpe_clear) else $error("master enable not cleared");

   property p_mpe_hold;
      @(posedge mclk_i) disable iff (!resetn_i)
      mpe_set |=> mpe_on [*4];
   endproperty
   a_mpe_hold: assert property (p_mpe_hold) else $error("master enable dropped early");

   property p_no_start;
      @(posedge mclk_i) disable iff (!resetn_i)
      pe_wr && !mpe_on && !busy |=> !busy;
   endproperty
   a_no_start: assert property (p_no_start) else $error("start without master enable");

   property p_start;
      @(posedge mclk_i) disable iff (!resetn_i)
      start |=> busy ##0 stall_o [*2] ##1 !stall_o;
   endproperty
   a_start: assert property (p_start) else $error("start did not set busy and stall");

   property p_busy_hold;
      @(posedge mclk_i) disable iff (!por_resetn_i)
      busy && !done |=> busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

   property p_mode_stable;
      @(posedge mclk_i) disable iff (!por_resetn_i)
      busy |=> $stable(mode_ff);
   endproperty
   a_mode_stable: assert property (p_mode_stable) else $error("mode changed while busy");

   property p_addr_stable;
      @(posedge mclk_i) disable iff (!resetn_i)
      busy |=> $stable(addr_ff);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address changed while busy");

   property p_read;
      @(posedge mclk_i) disable iff (!resetn_i)
      rd_go |=> data_ff == $past(mem_rd) ##0 stall_o [*4] ##1 !stall_o;
   endproperty
   a_read: assert property (p_read) else $error("read data or stall wrong");

   property p_irq_busy;
      @(posedge mclk_i) disable iff (!resetn_i)
      busy |-> !ready_irq_o;
   endproperty
   a_irq_busy: assert property (p_irq_busy) else $error("ready irq while busy");

   property p_gp2;
      @(posedge mclk_i) disable iff (!resetn_i)
      wr_gp2 && !io_bit_op_i |=> gp2_ff == $past(io_wdata_i);
   endproperty
   a_gp2: assert property (p_gp2) else $error("store register lost write");

   c_read:   cover property (@(posedge mclk_i) disable iff (!resetn_i) rd_go);
   c_atomic: cover property (@(posedge mclk_i) disable iff (!resetn_i)
                             start && mode_ff == eac_pkg::EAC_MODE_ATOMIC);
   c_erase:  cover property (@(posedge mclk_i) disable iff (!resetn_i)
                             start && mode_ff == eac_pkg::EAC_MODE_ERASE);
   c_bitop:  cover property (@(posedge mclk_i) disable iff (!resetn_i)
                             wr_go && io_bit_op_i);
endmodule

// [tb/eac_core_model.sv]
// Core-side model: I/O bus master and calibrated oscillator source
`timescale 1ns/1ps
module eac_core_model #(
   parameter int unsigned OSC_HALF = 50
)(
   input  wire logic       mclk_i,
   input  wire logic       stall_i,
   input  wire logic [7:0] rdata_i,
   output logic            osc_o,
   output logic [6:0]      addr_o,
   output logic            dspace_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic [7:0]      wdata_o,
   output logic            bit_op_o,
   output logic            bit_val_o,
   output logic [2:0]      bit_sel_o
);
   // ==========================================
   // Oscillator, free running and unrelated in phase to the core clock
   initial begin
      osc_o = 1'b0;
      #7;
      forever #(OSC_HALF) osc_o = ~osc_o;
   end

   initial begin
      addr_o    = 7'h00;
      dspace_o  = 1'b0;
      wr_o      = 1'b0;
      rd_o      = 1'b0;
      wdata_o   = 8'h00;
      bit_op_o  = 1'b0;
      bit_val_o = 1'b0;
      bit_sel_o = 3'h0;
   end

   // ==========================================
   // Bus cycles; a halted core issues nothing until the stall ends
   task automatic start(input logic [6:0] a, input logic ds);
      @(posedge mclk_i);
      #2;
      while (stall_i === 1'b1) begin
         @(posedge mclk_i);
         #2;
      end
      addr_o   = a;
      dspace_o = ds;
   endtask

   task automatic wr(input logic [6:0] a, input logic ds, input logic [7:0] d);
      start(a, ds);
      wdata_o = d;
      wr_o    = 1'b1;
      @(posedge mclk_i);
      #2;
      wr_o    = 1'b0;
      // Released data lines must not keep showing the last byte
      wdata_o = ~d;
   endtask

   task automatic bitop(input logic [6:0] a, input logic [2:0] sel, input logic v);
      start(a, 1'b0);
      bit_op_o  = 1'b1;
      bit_sel_o = sel;
      bit_val_o = v;
      wr_o      = 1'b1;
      @(posedge mclk_i);
      #2;
      wr_o      = 1'b0;
      bit_op_o  = 1'b0;
      bit_val_o = ~v;
   endtask

   task automatic rd(input logic [6:0] a, input logic ds, output logic [7:0] d);
      start(a, ds);
      rd_o = 1'b1;
      @(posedge mclk_i);
      #2;
      rd_o = 1'b0;
      d    = rdata_i;
   endtask
endmodule

// [tb/eac_ctrl_tb.sv]
// Self-checking bench for the data NVM access controller
`timescale 1ns/1ps
`include "eac_cfg.svh"
`define EAC_CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("unexpected %s: expected %h seen %h", nm, ex, gt); end end
module eac_ctrl_tb;
   localparam int LT   = 8;
   localparam int ST   = 4;
   localparam int OC   = 4;
   localparam int LO_L = (LT - 1) * OC;
   localparam int HI_L = (LT + 1) * OC + 8;
   localparam int LO_S = (ST - 1) * OC;
   localparam int HI_S = (ST + 1) * OC + 8;
   localparam logic [6:0] A_GP = {1'b0, `EAC_IO_GP2};
   localparam logic [6:0] A_CT = {1'b0, `EAC_IO_CTRL};
   localparam logic [6:0] A_DT = {1'b0, `EAC_IO_DATA};
   localparam logic [6:0] A_AL = {1'b0, `EAC_IO_ADRL};
   localparam logic [6:0] A_AH = {1'b0, `EAC_IO_ADRH};
   logic       mclk_i;
   logic       resetn_i;
   logic       por_n;
   logic       gie;
   logic       osc;
   logic [6:0] addr;
   logic       dsp;
   logic       wr;
   logic       rd;
   logic [7:0] wdata;
   logic       bop;
   logic       bval;
   logic [2:0] bsel;
   logic [7:0] rdata;
   logic       irq;
   logic       stall;
   int         error_cnt = 0;
   int         n_checks  = 0;
   time        tps;

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   eac_core_model core (.mclk_i(mclk_i), .stall_i(stall), .rdata_i(rdata), .osc_o(osc),
      .addr_o(addr), .dspace_o(dsp), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
      .bit_op_o(bop), .bit_val_o(bval), .bit_sel_o(bsel));

   eac_ctrl #(.LONG_TICKS(LT), .SHORT_TICKS(ST)) uut (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .por_resetn_i(por_n), .calib_osc_i(osc), .io_addr_i(addr), .io_dspace_i(dsp),
      .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdata), .io_bit_op_i(bop),
      .io_bit_val_i(bval), .io_bit_sel_i(bsel), .global_irq_en_i(gie),
      .io_rdata_o(rdata), .ready_irq_o(irq), .stall_o(stall));

   // ==========================================
   // Shared helpers
   task automatic rchk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] ex,
                       input string nm);
      logic [7:0] d;
      core.rd(a, 1'b0, d);
      `EAC_CHK(nm, ex, d & m)
   endtask

   task automatic stalls(input int ex, input string nm);
      int n;
      n = 0;
      while (stall === 1'b1 && n < 20) begin
         n++;
         @(posedge mclk_i);
         #2;
      end
      `EAC_CHK(nm, ex, n)
   endtask

   task automatic prog(input logic [1:0] md, input logic [8:0] a, input logic [7:0] d,
                       input logic rie);
      core.wr(A_CT, 1'b0, {2'b00, md, rie, 3'h0});
      core.wr(A_AH, 1'b0, {7'h00, a[8]});
      core.wr(A_AL, 1'b0, a[7:0]);
      core.wr(A_DT, 1'b0, d);
      core.bitop(A_CT, 3'h2, 1'b1);
      core.bitop(A_CT, 3'h1, 1'b1);
      tps = $time;
   endtask

   task automatic idle(input int lo, input int hi, input string nm);
      logic [7:0] d;
      d = 8'h02;
      // Bounded poll so a stuck busy flag fails instead of hanging
      while (d[1] === 1'b1 && $time - tps < 20000) core.rd(A_CT, 1'b0, d);
      `EAC_CHK(nm, 1'b1, ($time - tps) / 25 >= lo && ($time - tps) / 25 <= hi)
   endtask

   task automatic rdback(input logic [7:0] ex, input string nm);
      core.bitop(A_CT, 3'h0, 1'b1);
      stalls(4, "rd_stall");
      rchk(A_DT, 8'hFF, ex, nm);
   endtask

   task automatic pulse_rst();
      resetn_i = 1'b0;
      repeat (4) @(posedge mclk_i);
      #2;
      resetn_i = 1'b1;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_regs();
      rchk(A_GP, 8'hFF, 8'h00, "gp_reset");
      rchk(A_DT, 8'hFF, 8'h00, "data_reset");
      rchk(A_CT, 8'hFF, 8'h00, "ctrl_reset");
      core.wr(`EAC_DS_OFS + A_GP, 1'b1, 8'hA5);
      rchk(A_GP, 8'hFF, 8'hA5, "gp_dspace");
      core.bitop(A_GP, 3'h6, 1'b1);
      core.bitop(A_GP, 3'h0, 1'b0);
      rchk(A_GP, 8'hFF, 8'hE4, "gp_bitop");
      core.wr(7'h0B, 1'b0, 8'h77);
      rchk(7'h0B, 8'hFF, 8'h00, "unmapped");
      core.wr(A_AH, 1'b0, 8'hFF);
      rchk(A_AH, 8'hFF, 8'h01, "adr_high");
      core.wr(A_DT, 1'b0, 8'h3C);
      rchk(A_DT, 8'hFF, 8'h3C, "data_rw");
   endtask

   task automatic t_atomic();
      prog(2'b00, 9'h1A5, 8'h5A, 1'b0);
      stalls(2, "prog_stall");
      rchk(A_CT, 8'h32, 8'h02, "busy_set");
      core.wr(A_CT, 1'b0, 8'h20);
      rchk(A_CT, 8'h30, 8'h00, "mode_locked");
      core.wr(A_AL, 1'b0, 8'h00);
      core.bitop(A_CT, 3'h0, 1'b1);
      `EAC_CHK("rd_busy_stall", 1'b0, stall)
      rchk(A_DT, 8'hFF, 8'h5A, "rd_refused");
      idle(LO_L, HI_L, "atomic_time");
      rchk(A_AL, 8'hFF, 8'hA5, "adr_locked");
      rdback(8'h5A, "atomic_data");
   endtask

   task automatic t_split();
      prog(2'b01, 9'h003, 8'h00, 1'b0);
      idle(LO_S, HI_S, "erase_time");
      rdback(8'hFF, "erased");
      prog(2'b10, 9'h003, 8'h3C, 1'b0);
      idle(LO_S, HI_S, "write_time");
      rdback(8'h3C, "written");
      prog(2'b11, 9'h003, 8'h00, 1'b0);
      rchk(A_CT, 8'h02, 8'h00, "mode_rsvd");
   endtask

   task automatic t_mpe();
      core.wr(A_CT, 1'b0, 8'h00);
      core.bitop(A_CT, 3'h1, 1'b1);
      rchk(A_CT, 8'h02, 8'h00, "pe_no_mpe");
      core.bitop(A_CT, 3'h2, 1'b1);
      rchk(A_CT, 8'h04, 8'h04, "mpe_set");
      @(posedge mclk_i);
      rchk(A_CT, 8'h04, 8'h00, "mpe_clear");
   endtask

   task automatic t_irq();
      gie = 1'b1;
      core.wr(A_CT, 1'b0, 8'h08);
      `EAC_CHK("irq_idle", 1'b1, irq)
      gie = 1'b0;
      @(posedge mclk_i);
      #2;
      `EAC_CHK("irq_gie_off", 1'b0, irq)
      gie = 1'b1;
      prog(2'b00, 9'h004, 8'h81, 1'b1);
      stalls(2, "irq_stall");
      `EAC_CHK("irq_busy", 1'b0, irq)
      idle(LO_L, HI_L, "irq_prog");
      `EAC_CHK("irq_ready", 1'b1, irq)
   endtask

   task automatic t_rst_busy();
      prog(2'b01, 9'h010, 8'h00, 1'b0);
      idle(LO_S, HI_S, "pre_erase");
      prog(2'b10, 9'h010, 8'hC3, 1'b0);
      pulse_rst();
      rchk(A_CT, 8'h32, 8'h22, "busy_survives");
      idle(LO_S, HI_S, "rst_prog");
      core.wr(A_AH, 1'b0, 8'h00);
      core.wr(A_AL, 1'b0, 8'h10);
      rdback(8'hC3, "rst_data");
      core.wr(A_CT, 1'b0, 8'h10);
      pulse_rst();
      rchk(A_CT, 8'hFF, 8'h00, "mode_reset");
   endtask

   // ==========================================
   // Verdict, sequence and watchdog
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      resetn_i = 1'b0;
      por_n    = 1'b0;
      gie      = 1'b0;
      tps      = 0;
      repeat (4) @(posedge mclk_i);
      #2;
      resetn_i = 1'b1;
      por_n    = 1'b1;
      t_regs();
      t_atomic();
      t_split();
      t_mpe();
      t_irq();
      t_rst_busy();
      print_verdict();
   end

   initial begin
      #400000;
      error_cnt++;
      print_verdict();
   end
endmodule
